// ---- video_cfg_pkg.sv ----
// constants, register map and encodings for the video input configuration bank
// assumes a 200 mhz system clock and byte addresses of four times the register index
package video_cfg_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_INPUT_FORMAT_SELECT   = 8'h01;
	localparam logic [7:0] IDX_TEMPORAL_DECIMATION   = 8'h02;
	localparam logic [7:0] IDX_WINDOW_UPPER_BITS     = 8'h03;
	localparam logic [7:0] IDX_VERTICAL_OFFSET_LOW   = 8'h04;
	localparam logic [7:0] IDX_DECODER_STATE         = 8'h10;
	localparam int         ADDR_W                    = 8;
	localparam int         IDX_LSB                   = 2;

	// reset values
	localparam logic [7:0] RST_INPUT_FORMAT_SELECT   = 8'h58;
	localparam logic [7:0] RST_TEMPORAL_DECIMATION   = 8'h00;
	localparam logic [7:0] RST_WINDOW_UPPER_BITS     = 8'h12;
	localparam logic [7:0] RST_VERTICAL_OFFSET_LOW   = 8'h16;

	// input format select fields
	localparam int POS_ACTIVE_PIXEL_WINDOW   = 7;
	localparam int POS_INPUT_SELECT_HI       = 6;
	localparam int POS_INPUT_SELECT_LO       = 5;
	localparam int POS_CRYSTAL_HI            = 4;
	localparam int POS_CRYSTAL_LO            = 3;
	localparam int POS_FORMAT_HI             = 2;

	// temporal decimation fields
	localparam int POS_DROP_BY_FIELD         = 7;
	localparam int POS_DROP_START_PARITY     = 6;
	localparam int POS_DROP_COUNT_HI         = 5;

	// window upper bits fields
	localparam int POS_VOFFSET_HI            = 7;
	localparam int POS_VERTICAL_ACTIVE_LINES_HI            = 5;
	localparam int POS_HOFFSET_HI            = 3;
	localparam int POS_ACTIVE_PIXEL_WINDOW_HI            = 1;

	// video input selector codes
	localparam logic [1:0] SEL_INPUT_3 = 2'h0;
	localparam logic [1:0] SEL_INPUT_2 = 2'h1;
	localparam logic [1:0] SEL_INPUT_0 = 2'h2;
	localparam logic [1:0] SEL_INPUT_1 = 2'h3;

	// crystal choice codes
	localparam logic [1:0] XTAL_RESERVED = 2'h0;
	localparam logic [1:0] XTAL_ONLY_0   = 2'h1;
	localparam logic [1:0] XTAL_FORCE_1  = 2'h2;
	localparam logic [1:0] XTAL_AUTO     = 2'h3;

	// format codes
	typedef enum logic [2:0] {
		FMT_AUTO       = 3'h0,
		FMT_NTSC_M     = 3'h1,
		FMT_NTSC_NOPED = 3'h2,
		FMT_PAL_BDGHI  = 3'h3,
		FMT_PAL_M      = 3'h4,
		FMT_PAL_N      = 3'h5,
		FMT_SECAM      = 3'h6,
		FMT_PAL_NCOMB  = 3'h7
	} video_format_e;

	// decimation sequencer states
	typedef enum logic [1:0] {
		DEC_IDLE = 2'h0,
		DEC_WAIT = 2'h1,
		DEC_RUN  = 2'h2
	} decimation_state_e;

	// decimation totals per second of video
	localparam logic [6:0] UNITS_525 = 7'h3c;
	localparam logic [6:0] UNITS_625 = 7'h32;

	// line standard detection
	localparam logic [9:0] LINES_625_MIN    = 10'h120;
	localparam logic [4:0] FIELDS_TO_CHANGE = 5'h1f;
	localparam int         LINE_CNT_W       = 10;
	localparam int         PIX_CNT_W        = 16;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : video_cfg_pkg

// ---- video_input_format_window_upper_bits_config.sv ----
// configuration bank for the video decoder front end: input mux, crystal and format,
// temporal decimation and the upper bits of the cropping window, behind an axi4-lite slave
// assumes sync reset pins arrive asynchronously and one video sample per sys_clk
//
// Contract
// - host may read and write every register at any time, no video wait; the decoder state register here is read only
// - input format bit 7 selects active window end at or beyond horizontal reset
// - selector 00 input 3, 01 input 2, 10 input 0, 11 input 1
// - four composite sources, or three composite plus one luma chroma pair
// - crystal 01 crystal 0, 10 crystal 1, 11 automatic, 00 reserved
// - format 000 detects standard automatically from the line count status
// - manual codes pick ntsc, pal or secam variants; 100 taken as pal m
// - decimation bit 7 drops frames at 0, fields at 1
// - alignment bit picks odd or even as first dropped field
// - drop count is units dropped per 60 for 525 or per 50 for 625
// - drop count sits in low six bits of the decimation register
// - drop count zero disables dropping, everything passes
// - upper bits 7:6 vertical offset, 5:4 vertical active line count
// - upper bits 3:2 horizontal offset, 1:0 horizontal active pixel count
// - ten bit vertical offset counts half lines after vertical reset
// - vertical offset low byte holds bits 7:0 of the ten bit value
// - line standard 0 for 525, 1 for 625, changes after 32 equal fields
// - field parity tracked from horizontal and vertical reset relation
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps

module video_input_format_window_upper_bits_config
	import video_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	// axi4-lite write address
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]          s_axi_awprot,
	// axi4-lite write data
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	// axi4-lite write response
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic [1:0]               s_axi_bresp,
	// axi4-lite read address
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]          s_axi_arprot,
	// axi4-lite read data
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	// video sync pins, asynchronous
	input  wire logic                horizontal_sync_reset,
	input  wire logic                vertical_sync_reset,
	// analog front end samples
	input  wire logic [7:0]          video_input_0,
	input  wire logic [7:0]          video_input_1,
	input  wire logic [7:0]          video_input_2,
	input  wire logic [7:0]          video_input_3,
	input  wire logic [7:0]          separate_chroma_input,
	// selected video
	output logic [7:0]               selected_video_output,
	output logic [7:0]               selected_chroma_output,
	// settings to the pixel timing logic
	output logic                     active_pixel_window,
	output logic                     crystal_port_1_selected,
	output logic [2:0]               effective_format,
	output logic [9:0]               vertical_offset_half_lines,
	output logic [1:0]               vertical_active_upper,
	output logic [1:0]               horizontal_offset_upper,
	output logic [1:0]               horizontal_active_upper,
	// decoder state
	output logic                     line_count_standard,
	output logic                     field_is_even,
	output logic                     field_drop
);

	// register storage
	logic [7:0]          input_format_select_ff;
	logic [7:0]          temporal_decimation_control_ff;
	logic [7:0]          window_upper_bits_ff;
	logic [7:0]          vertical_offset_low_ff;

	// bus slave state
	logic                aw_held_ff;
	logic                w_held_ff;
	logic [ADDR_W-1:0]   aw_addr_ff;
	logic [7:0]          w_byte_ff;
	logic                w_lane0_ff;
	logic                bvalid_ff;
	logic [1:0]          bresp_ff;
	logic                rvalid_ff;
	logic [31:0]         rdata_ff;
	logic [1:0]          rresp_ff;

	// sync pin capture, three stages each
	logic [2:0]          hs_sync_ff;
	logic [2:0]          vs_sync_ff;
	logic                hs_level_ff;
	logic                vs_level_ff;

	// line and field measurement
	logic [PIX_CNT_W-1:0]  pix_cnt_ff;
	logic [PIX_CNT_W-1:0]  line_len_ff;
	logic [LINE_CNT_W-1:0] line_cnt_ff;
	logic [4:0]            agree_cnt_ff;
	logic                  line_std_ff;
	logic                  field_even_ff;

	// decimation and the registered video path
	decimation_state_e   dec_state_ff;
	logic [6:0]          dec_acc_ff;
	logic                drop_ff;
	logic [7:0]          vid_ff;
	logic [7:0]          chroma_ff;

	// decode helpers
	function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		idx_hit = (addr[ADDR_W-1:IDX_LSB] == idx[ADDR_W-IDX_LSB-1:0])
			&& (addr[IDX_LSB-1:0] == 2'h0);
	endfunction : idx_hit

	function automatic logic idx_mapped(input logic [ADDR_W-1:0] addr);
		idx_mapped = idx_hit(addr, IDX_INPUT_FORMAT_SELECT)
			|| idx_hit(addr, IDX_TEMPORAL_DECIMATION)
			|| idx_hit(addr, IDX_WINDOW_UPPER_BITS)
			|| idx_hit(addr, IDX_VERTICAL_OFFSET_LOW)
			|| idx_hit(addr, IDX_DECODER_STATE);
	endfunction : idx_mapped

	// edges of the filtered sync levels
	logic hs_agree;
	logic vs_agree;
	logic hs_rise;
	logic vs_rise;
	assign hs_agree = (hs_sync_ff[1] == hs_sync_ff[2]);
	assign vs_agree = (vs_sync_ff[1] == vs_sync_ff[2]);
	assign hs_rise  = hs_agree && hs_sync_ff[2] && !hs_level_ff;
	assign vs_rise  = vs_agree && vs_sync_ff[2] && !vs_level_ff;

	// write path: address and data may arrive in either order
	logic do_write;
	logic wr_dec;
	logic [7:0] wr_val;
	assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_val   = w_byte_ff;
	assign wr_dec   = do_write && w_lane0_ff && idx_hit(aw_addr_ff, IDX_TEMPORAL_DECIMATION);

	assign s_axi_awready = !aw_held_ff;
	assign s_axi_wready  = !w_held_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
		end else if (s_axi_awvalid && !aw_held_ff) begin
			aw_held_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_held_ff  <= 1'b0;
			w_byte_ff  <= 8'h00;
			w_lane0_ff <= 1'b0;
		end else if (s_axi_wvalid && !w_held_ff) begin
			w_held_ff  <= 1'b1;
			w_byte_ff  <= s_axi_wdata[7:0];
			w_lane0_ff <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= idx_mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// register writes; the state register is read only and lane 0 alone carries data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_format_select_ff         <= RST_INPUT_FORMAT_SELECT;
			temporal_decimation_control_ff <= RST_TEMPORAL_DECIMATION;
			window_upper_bits_ff           <= RST_WINDOW_UPPER_BITS;
			vertical_offset_low_ff         <= RST_VERTICAL_OFFSET_LOW;
		end else if (do_write && w_lane0_ff) begin
			if (idx_hit(aw_addr_ff, IDX_INPUT_FORMAT_SELECT)) begin
				input_format_select_ff <= wr_val;
			end
			if (idx_hit(aw_addr_ff, IDX_TEMPORAL_DECIMATION)) begin
				temporal_decimation_control_ff <= wr_val;
			end
			if (idx_hit(aw_addr_ff, IDX_WINDOW_UPPER_BITS)) begin
				window_upper_bits_ff <= wr_val;
			end
			if (idx_hit(aw_addr_ff, IDX_VERTICAL_OFFSET_LOW)) begin
				vertical_offset_low_ff <= wr_val;
			end
		end
	end

	// read path, answered one cycle after the address is taken
	logic [7:0] rd_val;
	always_comb begin
		rd_val = 8'h00;
		if (idx_hit(s_axi_araddr, IDX_INPUT_FORMAT_SELECT)) begin
			rd_val = input_format_select_ff;
		end else if (idx_hit(s_axi_araddr, IDX_TEMPORAL_DECIMATION)) begin
			rd_val = temporal_decimation_control_ff;
		end else if (idx_hit(s_axi_araddr, IDX_WINDOW_UPPER_BITS)) begin
			rd_val = window_upper_bits_ff;
		end else if (idx_hit(s_axi_araddr, IDX_VERTICAL_OFFSET_LOW)) begin
			rd_val = vertical_offset_low_ff;
		end else if (idx_hit(s_axi_araddr, IDX_DECODER_STATE)) begin
			rd_val = {2'h0, dec_state_ff, drop_ff, crystal_port_1_selected,
				field_even_ff, line_std_ff};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h00_0000, rd_val};
			rresp_ff  <= idx_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// sync pin capture: a level counts once the second and third stages agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_sync_ff  <= 3'h0;
			vs_sync_ff  <= 3'h0;
			hs_level_ff <= 1'b0;
			vs_level_ff <= 1'b0;
		end else begin
			hs_sync_ff <= {hs_sync_ff[1:0], horizontal_sync_reset};
			vs_sync_ff <= {vs_sync_ff[1:0], vertical_sync_reset};
			if (hs_agree) begin
				hs_level_ff <= hs_sync_ff[2];
			end
			if (vs_agree) begin
				vs_level_ff <= vs_sync_ff[2];
			end
		end
	end

	// line timing: position within the line and last full line length
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pix_cnt_ff  <= '0;
			line_len_ff <= '0;
		end else if (hs_rise) begin
			pix_cnt_ff  <= '0;
			line_len_ff <= pix_cnt_ff;
		end else if (pix_cnt_ff != '1) begin
			pix_cnt_ff <= pix_cnt_ff + 1'b1;
		end
	end

	// field parity: vertical reset past mid-line marks an even field; one on a line start is odd
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			field_even_ff <= 1'b0;
		end else if (vs_rise) begin
			field_even_ff <= !hs_rise && (pix_cnt_ff > (line_len_ff >> 1));
		end
	end

	// line count per field, filtered over consecutive fields before the standard flips
	logic field_is_625;
	assign field_is_625 = (line_cnt_ff >= LINES_625_MIN);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_cnt_ff <= '0;
		end else if (vs_rise) begin
			line_cnt_ff <= '0;
		end else if (hs_rise && line_cnt_ff != '1) begin
			line_cnt_ff <= line_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			agree_cnt_ff <= 5'h00;
			line_std_ff  <= 1'b0;
		end else if (vs_rise) begin
			if (field_is_625 == line_std_ff) begin
				agree_cnt_ff <= 5'h00;
			end else if (agree_cnt_ff == FIELDS_TO_CHANGE) begin
				agree_cnt_ff <= 5'h00;
				line_std_ff  <= field_is_625;
			end else begin
				agree_cnt_ff <= agree_cnt_ff + 1'b1;
			end
		end
	end

	// decimation: the accumulator drops count units out of every total
	logic [5:0] drop_count;
	logic       drop_by_field;
	logic       drop_start_parity;
	logic [6:0] units_total;
	logic [6:0] acc_sum;
	logic       new_field_even;
	logic       parity_match;
	logic       unit_start;
	assign drop_count        = temporal_decimation_control_ff[POS_DROP_COUNT_HI:0];
	assign drop_by_field     = temporal_decimation_control_ff[POS_DROP_BY_FIELD];
	assign drop_start_parity = temporal_decimation_control_ff[POS_DROP_START_PARITY];
	assign units_total       = line_std_ff ? UNITS_625 : UNITS_525;
	assign acc_sum           = dec_acc_ff + {1'b0, drop_count};
	assign new_field_even    = !hs_rise && (pix_cnt_ff > (line_len_ff >> 1));
	assign parity_match      = (new_field_even == drop_start_parity);
	// in frame mode only the first field of each frame makes a decision
	assign unit_start        = drop_by_field || parity_match;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_state_ff <= DEC_IDLE;
			dec_acc_ff   <= 7'h00;
			drop_ff      <= 1'b0;
		end else if (wr_dec) begin
			// a new setting restarts alignment; zero stops dropping at once
			dec_state_ff <= (wr_val[POS_DROP_COUNT_HI:0] == 6'h00) ? DEC_IDLE : DEC_WAIT;
			dec_acc_ff   <= 7'h00;
			drop_ff      <= 1'b0;
		end else begin
			case (dec_state_ff)
				DEC_IDLE: begin
					drop_ff <= 1'b0;
					if (drop_count != 6'h00) begin
						dec_state_ff <= DEC_WAIT;
					end
				end
				DEC_WAIT: begin
					if (vs_rise && parity_match) begin
						// first unit aligned to the chosen parity is dropped
						dec_state_ff <= DEC_RUN;
						dec_acc_ff   <= 7'h00;
						drop_ff      <= 1'b1;
					end
				end
				DEC_RUN: begin
					if (drop_count == 6'h00) begin
						dec_state_ff <= DEC_IDLE;
						drop_ff      <= 1'b0;
					end else if (vs_rise && unit_start) begin
						if (acc_sum >= units_total) begin
							dec_acc_ff <= acc_sum - units_total;
							drop_ff    <= 1'b1;
						end else begin
							dec_acc_ff <= acc_sum;
							drop_ff    <= 1'b0;
						end
					end
				end
				default: begin
					dec_state_ff <= DEC_IDLE;
					drop_ff      <= 1'b0;
				end
			endcase
		end
	end

	// input selector and registered video path
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			vid_ff    <= 8'h00;
			chroma_ff <= 8'h00;
		end else begin
			case (input_format_select_ff[POS_INPUT_SELECT_HI:POS_INPUT_SELECT_LO])
				SEL_INPUT_3: vid_ff <= video_input_3;
				SEL_INPUT_2: vid_ff <= video_input_2;
				SEL_INPUT_0: vid_ff <= video_input_0;
				SEL_INPUT_1: vid_ff <= video_input_1;
				default:     vid_ff <= video_input_0;
			endcase
			// chroma of a separated source rides beside whichever input carries its luma
			chroma_ff <= separate_chroma_input;
		end
	end

	assign selected_video_output  = vid_ff;
	assign selected_chroma_output = chroma_ff;

	// crystal choice; the reserved code falls back to crystal 0 rather than float
	logic [1:0] crystal_choice;
	assign crystal_choice = input_format_select_ff[POS_CRYSTAL_HI:POS_CRYSTAL_LO];
	always_comb begin
		case (crystal_choice)
			XTAL_ONLY_0:   crystal_port_1_selected = 1'b0;
			XTAL_FORCE_1:  crystal_port_1_selected = 1'b1;
			XTAL_AUTO:     crystal_port_1_selected = line_std_ff;
			XTAL_RESERVED: crystal_port_1_selected = 1'b0;
			default:       crystal_port_1_selected = 1'b0;
		endcase
	end

	// format: automatic picks ntsc m or pal from the filtered line standard
	video_format_e fmt_code;
	assign fmt_code = video_format_e'(input_format_select_ff[POS_FORMAT_HI:0]);
	always_comb begin
		case (fmt_code)
			FMT_AUTO: effective_format = line_std_ff ? FMT_PAL_BDGHI : FMT_NTSC_M;
			default:  effective_format = fmt_code;
		endcase
	end

	// settings out to the pixel timing logic, and the decoder state outputs
	assign active_pixel_window        = input_format_select_ff[POS_ACTIVE_PIXEL_WINDOW];
	assign vertical_offset_half_lines = {window_upper_bits_ff[POS_VOFFSET_HI -: 2],
		vertical_offset_low_ff};
	assign vertical_active_upper      = window_upper_bits_ff[POS_VERTICAL_ACTIVE_LINES_HI -: 2];
	assign horizontal_offset_upper    = window_upper_bits_ff[POS_HOFFSET_HI -: 2];
	assign horizontal_active_upper    = window_upper_bits_ff[POS_ACTIVE_PIXEL_WINDOW_HI -: 2];
	assign line_count_standard        = line_std_ff;
	assign field_is_even              = field_even_ff;
	assign field_drop                 = drop_ff;

endmodule : video_input_format_window_upper_bits_config

// ---- video_cfg_monitor.sv ----
// assertions on the ports of the video configuration bank
// assumes one clock domain and reads that are not overlapped by writes to the same register
`timescale 1ns/1ps
module video_cfg_monitor
	import video_cfg_pkg::*;
(
	// clock and reset
	input wire logic              sys_clk,
	input wire logic              rst_n,
	// register bus
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_rvalid,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_bvalid,
	input wire logic [1:0]        s_axi_bresp,
	// video
	input wire logic [7:0]        video_input_0,
	input wire logic [7:0]        video_input_1,
	input wire logic [7:0]        video_input_2,
	input wire logic [7:0]        video_input_3,
	input wire logic [7:0]        selected_video_output,
	// settings and decoder state
	input wire logic              active_pixel_window,
	input wire logic              crystal_port_1_selected,
	input wire logic [2:0]        effective_format,
	input wire logic [9:0]        vertical_offset_half_lines,
	input wire logic [1:0]        vertical_active_upper,
	input wire logic [1:0]        horizontal_offset_upper,
	input wire logic [1:0]        horizontal_active_upper,
	input wire logic              line_count_standard,
	input wire logic              field_drop
);
	logic [ADDR_W-1:0] rd_ff;
	wire               rv4 = s_axi_rvalid && rd_ff == 8'h04;
	wire               rv8 = s_axi_rvalid && rd_ff == 8'h08;
	wire               rvc = s_axi_rvalid && rd_ff == 8'h0c;
	wire               rvl = s_axi_rvalid && rd_ff == 8'h10;
	wire [1:0]         sel = s_axi_rdata[6:5];
	// read address kept so returned data can be tied to the live outputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) rd_ff <= '0;
		else if (s_axi_arvalid && s_axi_arready) rd_ff <= s_axi_araddr;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read data not returned in one cycle");
	property p_rd_word; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_rd_word: assert property (p_rd_word)
		else $error("upper read data bits not zero");
	property p_apw; rv4 |-> active_pixel_window == s_axi_rdata[7]; endproperty
	a_apw: assert property (p_apw)
		else $error("active window bit mismatch");
	property p_mux;
		rv4 |-> selected_video_output == (sel == 2'h0 ? $past(video_input_3) :
			sel == 2'h1 ? $past(video_input_2) :
			sel == 2'h2 ? $past(video_input_0) : $past(video_input_1));
	endproperty
	a_mux: assert property (p_mux)
		else $error("wrong video input routed");
	property p_xtal;
		rv4 |-> crystal_port_1_selected == ((s_axi_rdata[4:3] == XTAL_FORCE_1 ||
			(s_axi_rdata[4:3] == XTAL_AUTO && line_count_standard)));
	endproperty
	a_xtal: assert property (p_xtal)
		else $error("crystal choice mismatch");
	property p_fmt;
		rv4 |-> effective_format == (s_axi_rdata[2:0] != 3'h0 ? s_axi_rdata[2:0] :
			(line_count_standard ? 3'h3 : 3'h1));
	endproperty
	a_fmt: assert property (p_fmt)
		else $error("format decode mismatch");
	property p_drop0; rv8 && s_axi_rdata[5:0] == 6'h0 |-> !field_drop; endproperty
	a_drop0: assert property (p_drop0)
		else $error("dropping with zero count");
	property p_upper;
		rvc |-> {vertical_offset_half_lines[9:8], vertical_active_upper,
			horizontal_offset_upper, horizontal_active_upper} == s_axi_rdata[7:0];
	endproperty
	a_upper: assert property (p_upper)
		else $error("window upper bits mismatch");
	property p_vlow; rvl |-> vertical_offset_half_lines[7:0] == s_axi_rdata[7:0]; endproperty
	a_vlow: assert property (p_vlow)
		else $error("vertical offset low byte mismatch");
	c_drop: cover property ($rose(field_drop));
	c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	c_dec: cover property (rv8);
endmodule : video_cfg_monitor

bind video_input_format_window_upper_bits_config video_cfg_monitor video_cfg_monitor_inst (
	.sys_clk, .rst_n, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
	.s_axi_rdata, .s_axi_bvalid, .s_axi_bresp, .video_input_0, .video_input_1,
	.video_input_2, .video_input_3, .selected_video_output, .active_pixel_window,
	.crystal_port_1_selected, .effective_format, .vertical_offset_half_lines,
	.vertical_active_upper, .horizontal_offset_upper, .horizontal_active_upper,
	.line_count_standard, .field_drop);

// ---- video_input_format_window_upper_bits_config_tb.sv ----
// self-checking bench for the video configuration bank over axi4-lite
// assumes the bound monitor and short synthetic fields of twelve lines
`timescale 1ns/1ps
module video_input_format_window_upper_bits_config_tb
	import video_cfg_pkg::*;
;
	logic        sys_clk = 0, rst_n = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 0;
	logic        horizontal_sync_reset = 0, vertical_sync_reset = 0;
	logic [7:0]  video_input_0 = 8'h10, video_input_1 = 8'h21, video_input_2 = 8'h42;
	logic [7:0]  video_input_3 = 8'h83, separate_chroma_input = 8'h5a;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [7:0]  selected_video_output, selected_chroma_output;
	logic        active_pixel_window, crystal_port_1_selected, line_count_standard;
	logic        field_is_even, field_drop;
	logic [2:0]  effective_format;
	logic [9:0]  vertical_offset_half_lines;
	logic [1:0]  vertical_active_upper, horizontal_offset_upper, horizontal_active_upper;
	logic [31:0] rd;
	int          miscompares = 0, check_count = 0;
	logic [7:0]  ad [4] = '{8'h04, 8'h08, 8'h0c, 8'h10};
	logic [7:0]  rv [4] = '{8'h58, 8'h00, 8'h12, 8'h16};
	logic [7:0]  mx [4] = '{8'h83, 8'h42, 8'h10, 8'h21};

	video_input_format_window_upper_bits_config video_input_format_window_upper_bits_config_inst (.*);

	initial forever #2.5 sys_clk = ~sys_clk;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask : chk

	// requests hold until a rising edge samples ready; answers are taken at that edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdr

	// vertical rise lands on a line start, so each field is odd
	task automatic fld();
		for (int l = 0; l < 12; l++) begin
			@(posedge sys_clk);
			horizontal_sync_reset <= 1'b1;
			vertical_sync_reset <= (l < 3);
			repeat (2) @(posedge sys_clk);
			horizontal_sync_reset <= 1'b0;
			repeat (8) @(posedge sys_clk);
		end
	endtask : fld

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rdr(ad[i]);
			chk("reset value", {24'h0, rv[i]}, rd);
		end
		$display("done reset values");
		wr(8'h0c, 8'hb4);
		wr(8'h10, 8'h01);
		chk("vertical offset", 32'h201, vertical_offset_half_lines);
		chk("upper fields", 32'h34, {vertical_active_upper, horizontal_offset_upper,
			horizontal_active_upper});
		rdr(8'h0c);
		chk("upper readback", 32'hb4, rd);
		rdr(8'h10);
		$display("done window");
		for (int s = 0; s < 4; s++) begin
			wr(8'h04, {1'b1, s[1:0], 5'h08});
			repeat (2) @(posedge sys_clk);
			chk("video output", {24'h0, mx[s]}, selected_video_output);
			chk("active window", 32'h1, active_pixel_window);
			rdr(8'h04);
		end
		chk("chroma", 32'h5a, selected_chroma_output);
		for (int c = 1; c < 4; c++) begin
			wr(8'h04, {3'b010, c[1:0], 3'h0});
			chk("crystal", 32'(c == 2), crystal_port_1_selected);
		end
		for (int f = 0; f < 8; f++) begin
			wr(8'h04, {5'h0b, f[2:0]});
			chk("format", f == 0 ? 32'h1 : 32'(f), effective_format);
		end
		chk("active window", 32'h0, active_pixel_window);
		$display("done format");
		wr(8'h14, 8'hff);
		chk("write resp", 32'h2, resp);
		rdr(8'h14);
		chk("read resp", 32'h2, resp);
		chk("read data", 32'h0, rd);
		$display("done unmapped");
		wr(8'h08, 8'h00);
		wr(8'h08, 8'hbc);
		chk("drop early", 32'h0, field_drop);
		repeat (3) fld();
		chk("drop fields", 32'h1, field_drop);
		rdr(8'h08);
		chk("decimation", 32'hbc, rd);
		wr(8'h08, 8'h00);
		chk("drop off", 32'h0, field_drop);
		fld();
		chk("drop idle", 32'h0, field_drop);
		chk("field parity", 32'h0, field_is_even);
		rdr(8'h08);
		wr(8'h08, 8'h41);
		fld();
		chk("drop even", 32'h0, field_drop);
		wr(8'h08, 8'h00);
		wr(8'h08, 8'h01);
		fld();
		chk("drop frame", 32'h1, field_drop);
		$display("done decimation");
		wrap_up();
	end
endmodule : video_input_format_window_upper_bits_config_tb
